// >>> hw/sdfe_map.svh
// Register map, field positions, reset values and timing counts
// Function
// R01 - Two-bit field picks reference pair
// R02 - Gain bit sets modulator gain one/two
// R03 - Amp enable gates all amp functions
// R04 - Bypass bit routes input past amp
// R05 - Amp gain is two to code
// R06 - Short bit ties input ends together
// R07 - Two-bit field routes ends onto amp
// R08 - Negative select maps channels and internals
// R09 - Positive select same map, sensor positive
// R10 - Software pairs single-ended with common-mode
// R11 - Software pairs temperature sensor outputs
// R12 - Low-noise amp enable, input, switches
// R13 - Low code shadowed until high written
// R14 - DAC code twelve bits across two
// R15 - DAC enable and reference select bits
// R16 - Result is three read-only bytes
// R17 - Filter bit picks sinc3 or sinc2
// R18 - Divide field gives 30 or 12
// R19 - Oversampling halves from 32768 to 128
// R20 - Latch enable freezes result registers
// R21 - Unimplemented bits read zero
// R22 - Latched: hold results, flag unchanged
// R23 - Hardware sets end flag, software clears
// R24 - Soft reset clears filter, blocks conversion
// R25 - Master clock is sysclk/2/(code+1)
// R26 - One result per OSR or 2xOSR clocks
// R27 - Result bytes update in one cycle
`ifndef SDFE_MAP_SVH
`define SDFE_MAP_SVH

`define SDFE_OFS_PGA_GAIN_REF   4'h0
`define SDFE_OFS_INPUT_CONN     4'h1
`define SDFE_OFS_CHANNEL_SEL    4'h2
`define SDFE_OFS_LOWNOISE_AMP   4'h3
`define SDFE_OFS_DAC_LOW        4'h4
`define SDFE_OFS_DAC_HIGH       4'h5
`define SDFE_OFS_DAC_CTRL       4'h6
`define SDFE_OFS_RESULT_LOW     4'h7
`define SDFE_OFS_RESULT_MID     4'h8
`define SDFE_OFS_RESULT_HIGH    4'h9
`define SDFE_OFS_FILTER_RATE    4'ha
`define SDFE_OFS_CONV_CTRL      4'hb
`define SDFE_OFS_MASTER_CLK     4'hc

`define SDFE_MASK_INPUT_CONN    8'he0
`define SDFE_MASK_LOWNOISE_AMP  8'h87
`define SDFE_MASK_DAC_LOW       8'h0f
`define SDFE_MASK_DAC_CTRL      8'hc0
`define SDFE_MASK_CONV_CTRL     8'h3c
`define SDFE_MASK_MASTER_CLK    8'h1f

`define SDFE_BIT_HOLD           5
`define SDFE_BIT_EOC            4
`define SDFE_BIT_SRST           3
`define SDFE_BIT_EN             2
`define SDFE_BIT_AMP_EN         4
`define SDFE_BIT_AMP_BYP        3

`define SDFE_RESET_BYTE         8'h00
`define SDFE_CLK_UNDIVIDED      5'h1f
`define SDFE_DIV_30             5'd30
`define SDFE_DIV_12             5'd12
`define SDFE_OSR_MAX_LOG2       5'd15
`define SDFE_OSR_CODE_MAX       4'h8

`endif

// >>> hw/sdfe_pkg.sv
// Types shared by the converter front-end control block
package sdfe_pkg;
    typedef enum logic [1:0] {
        SDFE_IDLE = 2'b00,
        SDFE_RUN  = 2'b01,
        SDFE_DONE = 2'b11
    } sdfe_state_type;
endpackage : sdfe_pkg

// >>> hw/sdfe_ctrl.sv
// Converter front-end control registers, decimator pacing and results
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`include "sdfe_map.svh"
module sdfe_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic [23:0] filter_data_i,
    output logic      [1:0]  ref_pair_sel_o,
    output logic             modulator_gain_sel_o,
    output logic             amp_en_o,
    output logic             amp_bypass_o,
    output logic      [2:0]  amp_gain_sel_o,
    output logic             input_short_o,
    output logic      [1:0]  input_route_sel_o,
    output logic      [3:0]  neg_input_sel_o,
    output logic      [3:0]  pos_input_sel_o,
    output logic             lownoise_amp_en_o,
    output logic             lownoise_pos_sel_o,
    output logic             lownoise_switch_1_o,
    output logic             lownoise_switch_0_o,
    output logic             dac_en_o,
    output logic             dac_ref_sel_o,
    output logic      [11:0] dac_code_o,
    output logic             filter_order_sel_o,
    output logic             converter_en_o,
    output logic             filter_clear_o,
    output logic             master_clk_tick_o,
    output logic             conv_clk_tick_o,
    output logic             result_ready_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  pga_gain_reference_ctrl_r;
    logic [7:0]  input_connection_ctrl_r;
    logic [7:0]  channel_select_r;
    logic [7:0]  low_noise_amp_ctrl_r;
    logic [7:0]  dac_shadow_r;
    logic [7:0]  dac_code_low_r;
    logic [7:0]  dac_code_high_r;
    logic [7:0]  dac_ctrl_r;
    logic [7:0]  filter_rate_ctrl_r;
    logic [7:0]  converter_ctrl_status_r;
    logic [7:0]  master_clk_div_r;
    logic [23:0] result_r;
    logic        ack_r;
    logic        err_r;
    logic [31:0] rdata_r;

    logic        req;
    logic        wr;
    logic [3:0]  idx;
    logic        mapped;
    logic [7:0]  wbyte;
    logic [7:0]  rd_nxt;

    assign req    = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign idx    = wb_adr_i[5:2];
    assign mapped = (idx <= `SDFE_OFS_MASTER_CLK) & (wb_adr_i[1:0] == 2'b00);
    assign wr     = req & wb_we_i & mapped & wb_sel_i[0];
    assign wbyte  = wb_dat_i[7:0];

    // ------------------------------------------------------------
    // Bus answer: one wait state, error on unmapped address
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            ack_r <= req & mapped;
            err_r <= req & ~mapped;
        end
    end

    always_comb begin
        rd_nxt = `SDFE_RESET_BYTE;
        // R21 unimplemented read zero
        case (idx)
            `SDFE_OFS_PGA_GAIN_REF: rd_nxt = pga_gain_reference_ctrl_r;
            `SDFE_OFS_INPUT_CONN:   rd_nxt = input_connection_ctrl_r;
            `SDFE_OFS_CHANNEL_SEL:  rd_nxt = channel_select_r;
            `SDFE_OFS_LOWNOISE_AMP: rd_nxt = low_noise_amp_ctrl_r;
            `SDFE_OFS_DAC_LOW:      rd_nxt = dac_code_low_r;
            `SDFE_OFS_DAC_HIGH:     rd_nxt = dac_code_high_r;
            `SDFE_OFS_DAC_CTRL:     rd_nxt = dac_ctrl_r;
            // R16 read-only result bytes
            `SDFE_OFS_RESULT_LOW:   rd_nxt = result_r[7:0];
            `SDFE_OFS_RESULT_MID:   rd_nxt = result_r[15:8];
            `SDFE_OFS_RESULT_HIGH:  rd_nxt = result_r[23:16];
            `SDFE_OFS_FILTER_RATE:  rd_nxt = filter_rate_ctrl_r;
            `SDFE_OFS_CONV_CTRL:    rd_nxt = converter_ctrl_status_r;
            `SDFE_OFS_MASTER_CLK:   rd_nxt = master_clk_div_r;
            default:                rd_nxt = `SDFE_RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (req) begin
            rdata_r <= {24'h00_0000, rd_nxt};
        end
    end

    assign wb_dat_o = rdata_r;
    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;

    // ------------------------------------------------------------
    // Analog front-end, filter rate and master clock control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pga_gain_reference_ctrl_r <= `SDFE_RESET_BYTE;
            input_connection_ctrl_r   <= `SDFE_RESET_BYTE;
            channel_select_r          <= `SDFE_RESET_BYTE;
            low_noise_amp_ctrl_r      <= `SDFE_RESET_BYTE;
            dac_ctrl_r                <= `SDFE_RESET_BYTE;
            filter_rate_ctrl_r        <= `SDFE_RESET_BYTE;
            master_clk_div_r          <= `SDFE_RESET_BYTE;
        end else if (wr) begin
            case (idx)
                `SDFE_OFS_PGA_GAIN_REF: pga_gain_reference_ctrl_r <= wbyte;
                // R21 writes to unimplemented bits ignored
                `SDFE_OFS_INPUT_CONN:
                    input_connection_ctrl_r <= wbyte & `SDFE_MASK_INPUT_CONN;
                `SDFE_OFS_CHANNEL_SEL:  channel_select_r <= wbyte;
                `SDFE_OFS_LOWNOISE_AMP:
                    low_noise_amp_ctrl_r <= wbyte & `SDFE_MASK_LOWNOISE_AMP;
                `SDFE_OFS_DAC_CTRL:
                    dac_ctrl_r <= wbyte & `SDFE_MASK_DAC_CTRL;
                `SDFE_OFS_FILTER_RATE:  filter_rate_ctrl_r <= wbyte;
                `SDFE_OFS_MASTER_CLK:
                    master_clk_div_r <= wbyte & `SDFE_MASK_MASTER_CLK;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // DAC code with shadowed low nibble
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_shadow_r    <= `SDFE_RESET_BYTE;
            dac_code_low_r  <= `SDFE_RESET_BYTE;
            dac_code_high_r <= `SDFE_RESET_BYTE;
        end else if (wr && idx == `SDFE_OFS_DAC_LOW) begin
            // R13 low write lands in shadow
            dac_shadow_r <= wbyte & `SDFE_MASK_DAC_LOW;
        end else if (wr && idx == `SDFE_OFS_DAC_HIGH) begin
            // R13 high write commits shadow
            dac_code_high_r <= wbyte;
            dac_code_low_r  <= dac_shadow_r;
        end
    end

    // R14 twelve-bit code assembly
    assign dac_code_o = {dac_code_high_r, dac_code_low_r[3:0]};

    // R15 DAC enable and reference
    assign dac_en_o      = dac_ctrl_r[7];
    assign dac_ref_sel_o = dac_ctrl_r[6];

    // R01 reference pair code
    assign ref_pair_sel_o       = pga_gain_reference_ctrl_r[7:6];
    // R02 modulator gain bit
    assign modulator_gain_sel_o = pga_gain_reference_ctrl_r[5];
    // R03 amp enable gates features
    assign amp_en_o = pga_gain_reference_ctrl_r[`SDFE_BIT_AMP_EN];
    // R04 bypass only when enabled
    assign amp_bypass_o = amp_en_o
                        & pga_gain_reference_ctrl_r[`SDFE_BIT_AMP_BYP];
    // R05 gain code, held at unity when disabled
    assign amp_gain_sel_o = amp_en_o ? pga_gain_reference_ctrl_r[2:0]
                                     : 3'h0;
    // R06 input short
    assign input_short_o     = input_connection_ctrl_r[7];
    // R07 routing code
    assign input_route_sel_o = input_connection_ctrl_r[6:5];
    // R08 negative select
    assign neg_input_sel_o   = channel_select_r[7:4];
    // R09 positive select
    assign pos_input_sel_o   = channel_select_r[3:0];
    // R12 low-noise amp bits
    assign lownoise_amp_en_o   = low_noise_amp_ctrl_r[7];
    assign lownoise_pos_sel_o  = low_noise_amp_ctrl_r[2];
    assign lownoise_switch_1_o = low_noise_amp_ctrl_r[1];
    assign lownoise_switch_0_o = low_noise_amp_ctrl_r[0];
    // R17 filter order
    assign filter_order_sel_o  = filter_rate_ctrl_r[7];

    // ------------------------------------------------------------
    // Clock tick generation
    // ------------------------------------------------------------
    logic [5:0]  mclk_cnt_r;
    logic [5:0]  mclk_top;
    logic        mclk_tick;
    logic [4:0]  adck_cnt_r;
    logic [4:0]  adck_div;
    logic        adck_tick;
    logic        run;

    assign run = converter_en_o & ~filter_clear_o;

    // R25 sysclk/2/(code+1), code all-ones undivided
    assign mclk_top  = {master_clk_div_r[4:0], 1'b1};
    assign mclk_tick = run & ((master_clk_div_r[4:0] == `SDFE_CLK_UNDIVIDED)
                     | (mclk_cnt_r >= mclk_top));

    always_ff @(posedge clk_i) begin
        if (rst_i || !run || mclk_tick) begin
            mclk_cnt_r <= 6'h00;
        end else begin
            mclk_cnt_r <= mclk_cnt_r + 6'h01;
        end
    end

    // R18 divide 30 or 12; reserved codes take 30
    assign adck_div  = filter_rate_ctrl_r[5:4] == 2'b10 ? `SDFE_DIV_12
                                                       : `SDFE_DIV_30;
    assign adck_tick = mclk_tick & (adck_cnt_r >= adck_div - 5'd1);

    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            adck_cnt_r <= 5'h00;
        end else if (mclk_tick) begin
            adck_cnt_r <= adck_tick ? 5'h00 : adck_cnt_r + 5'h01;
        end
    end

    assign master_clk_tick_o = mclk_tick;
    assign conv_clk_tick_o   = adck_tick;

    // ------------------------------------------------------------
    // Decimator pacing
    // ------------------------------------------------------------
    sdfe_pkg::sdfe_state_type state_r;
    logic [16:0] osr_cnt_r;
    logic [16:0] osr_top;
    logic [3:0]  osr_code;
    logic        done_tick;

    // R19 ratio halves per code; reserved codes clamp at 128
    assign osr_code = filter_rate_ctrl_r[3:0] > `SDFE_OSR_CODE_MAX
                    ? `SDFE_OSR_CODE_MAX : filter_rate_ctrl_r[3:0];
    // R26 sinc2 needs twice the periods
    assign osr_top = (17'h00001 << (`SDFE_OSR_MAX_LOG2 - {1'b0, osr_code}
                     + {4'h0, filter_order_sel_o})) - 17'h00001;
    // At or above top: a smaller ratio written mid-count cannot overrun
    assign done_tick = adck_tick & (state_r == sdfe_pkg::SDFE_RUN)
                     & (osr_cnt_r >= osr_top);

    always_ff @(posedge clk_i) begin
        // R24 soft reset aborts and holds off conversion
        if (rst_i || !run) begin
            state_r   <= sdfe_pkg::SDFE_IDLE;
            osr_cnt_r <= 17'h00000;
        end else begin
            case (state_r)
                sdfe_pkg::SDFE_IDLE: state_r <= sdfe_pkg::SDFE_RUN;
                sdfe_pkg::SDFE_RUN: begin
                    if (adck_tick) begin
                        osr_cnt_r <= done_tick ? 17'h00000
                                               : osr_cnt_r + 17'h00001;
                    end
                    if (done_tick) begin
                        state_r <= sdfe_pkg::SDFE_DONE;
                    end
                end
                sdfe_pkg::SDFE_DONE: state_r <= sdfe_pkg::SDFE_RUN;
                default: state_r <= sdfe_pkg::SDFE_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Results and converter control/status
    // ------------------------------------------------------------
    logic hold;
    logic set_eoc;
    logic ctrl_wr;

    assign hold    = converter_ctrl_status_r[`SDFE_BIT_HOLD];
    assign ctrl_wr = wr & (idx == `SDFE_OFS_CONV_CTRL);
    // R22 no flag change while latched
    assign set_eoc = (state_r == sdfe_pkg::SDFE_DONE) & ~hold;
    assign result_ready_o = set_eoc;

    // R27 all three bytes in one cycle; no reset, power-on unknown
    always_ff @(posedge clk_i) begin
        // R20 latch freezes results
        if (set_eoc) begin
            result_r <= filter_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_ctrl_status_r <= `SDFE_RESET_BYTE;
        end else begin
            if (ctrl_wr) begin
                converter_ctrl_status_r <= wbyte & `SDFE_MASK_CONV_CTRL;
            end
            // R23 set wins over software clear
            if (set_eoc) begin
                converter_ctrl_status_r[`SDFE_BIT_EOC] <= 1'b1;
            end
        end
    end

    assign converter_en_o = converter_ctrl_status_r[`SDFE_BIT_EN];
    assign filter_clear_o = converter_ctrl_status_r[`SDFE_BIT_SRST];

endmodule : sdfe_ctrl

// >>> verification/sdfe_ctrl_asserts.sv
// Concurrent checks on the converter front-end control ports
module sdfe_ctrl_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [1:0]  ref_pair_sel_o,
    input wire logic        modulator_gain_sel_o,
    input wire logic        amp_en_o,
    input wire logic        amp_bypass_o,
    input wire logic [2:0]  amp_gain_sel_o,
    input wire logic [11:0] dac_code_o,
    input wire logic        converter_en_o,
    input wire logic        filter_clear_o,
    input wire logic        result_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       take;
    logic       wr;
    logic [3:0] idx;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign idx  = wb_adr_i[5:2];
    assign wr   = take && wb_we_i && wb_sel_i[0] && wb_adr_i[1:0] == 2'h0;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_bus_answer: assert property (take |=> wb_ack_o ^ wb_err_o)
        else $error("bus request not answered");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o && !wb_err_o)
        else $error("ack longer than one cycle");
    a_err_unmapped: assert property ((take && (idx > 4'hc ||
        wb_adr_i[1:0] != 2'h0)) |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_ref_gain: assert property ((wr && idx == 4'h0) |=>
        ref_pair_sel_o == $past(wb_dat_i[7:6]) &&
        modulator_gain_sel_o == $past(wb_dat_i[5]))
        else $error("reference or gain select mismatch");
    a_amp_gated: assert property (!amp_en_o |->
        !amp_bypass_o && amp_gain_sel_o == 3'h0)
        else $error("amp feature active while disabled");
    a_dac_shadow: assert property ((wr && idx == 4'h4) |=>
        $stable(dac_code_o))
        else $error("low code reached output before commit");
    a_dac_commit: assert property ((wr && idx == 4'h5) |=>
        dac_code_o[11:4] == $past(wb_dat_i[7:0]))
        else $error("high code not committed");
    a_ready_pulse: assert property (result_ready_o |=>
        !result_ready_o [*8])
        else $error("result ready too close together");
    a_ready_run: assert property (result_ready_o |->
        $past(converter_en_o) && !$past(filter_clear_o))
        else $error("result while stopped or in soft reset");
endmodule : sdfe_ctrl_asserts

bind sdfe_ctrl sdfe_ctrl_asserts i_sdfe_ctrl_asserts (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .ref_pair_sel_o,
    .modulator_gain_sel_o, .amp_en_o, .amp_bypass_o, .amp_gain_sel_o,
    .dac_code_o, .converter_en_o, .filter_clear_o, .result_ready_o);

// >>> verification/testbench.sv
// Self-checking bench for the converter front-end control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [5:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, wb_err_o;
    logic [23:0] filter_data_i;
    logic [1:0]  ref_pair_sel_o, input_route_sel_o;
    logic        modulator_gain_sel_o, amp_en_o, amp_bypass_o, input_short_o;
    logic [2:0]  amp_gain_sel_o;
    logic [3:0]  neg_input_sel_o, pos_input_sel_o;
    logic        lownoise_amp_en_o, lownoise_pos_sel_o;
    logic        lownoise_switch_1_o, lownoise_switch_0_o;
    logic        dac_en_o, dac_ref_sel_o, filter_order_sel_o;
    logic [11:0] dac_code_o;
    logic        converter_en_o, filter_clear_o, master_clk_tick_o;
    logic        conv_clk_tick_o, result_ready_o;
    int          err_total, checks_done, rdy_cnt, cnv_cnt, n, k;
    logic [7:0]  r;
    logic        e;
    sdfe_ctrl i_sdfe_ctrl (.*);
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task xfer(input logic w, input logic [5:0] a, input logic [3:0] s,
              input logic [7:0] d, output logic [7:0] rd, output logic er);
        int t;
        t = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && t < 50);
        if (t >= 50) err_total++;
        rd = wb_dat_o[7:0];
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer
    task wr(input logic [3:0] i, input logic [7:0] d);
        xfer(1'b1, {i, 2'h0}, 4'h1, d, r, e);
    endtask : wr
    task rdc(input logic [3:0] i, input logic [7:0] x);
        xfer(1'b0, {i, 2'h0}, 4'h1, 8'h00, r, e);
        chk($sformatf("register %0d", i), {24'h0, x}, {24'h0, r});
    endtask : rdc
    // Pulse gap in cycles; m picks the master tick, else result ready
    task gap(input bit m);
        int w;
        w = 0;
        do begin
            @(posedge clk_i);
            w++;
        end while ((m ? master_clk_tick_o : result_ready_o) !== 1'b1
                   && w < 9000);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((m ? master_clk_tick_o : result_ready_o) !== 1'b1
                   && n < 9000);
    endtask : gap
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs;
        logic [7:0] m [7];
        m = '{8'hff, 8'he0, 8'hff, 8'h87, 8'h0f, 8'hff, 8'hc0};
        for (int i = 0; i < 13; i++) if (i < 7 || i > 9) rdc(i[3:0], 8'h00);
        for (int i = 0; i < 7; i++) wr(i[3:0], 8'hff);
        for (int i = 0; i < 7; i++) rdc(i[3:0], m[i]);
        wr(4'ha, 8'hff);
        rdc(4'ha, 8'hff);
        wr(4'hc, 8'hff);
        rdc(4'hc, 8'h1f);
        chk("pga outputs", 32'hff, {ref_pair_sel_o, modulator_gain_sel_o,
            amp_en_o, amp_bypass_o, amp_gain_sel_o});
        chk("input outputs", 32'h7ff, {input_short_o, input_route_sel_o,
            neg_input_sel_o, pos_input_sel_o});
        chk("misc outputs", 32'h7f, {lownoise_amp_en_o, lownoise_pos_sel_o,
            lownoise_switch_1_o, lownoise_switch_0_o, dac_en_o,
            dac_ref_sel_o, filter_order_sel_o});
        wr(4'h0, 8'h0f);
        rdc(4'h0, 8'h0f);
        chk("amp gated", 32'h0, {amp_bypass_o, amp_gain_sel_o});
        $display("test registers done");
    endtask : t_regs
    task t_bus;
        xfer(1'b0, 6'h34, 4'h1, 8'h00, r, e);
        chk("err index 13", 32'h1, {31'h0, e});
        xfer(1'b1, 6'h09, 4'h1, 8'h00, r, e);
        chk("err misaligned", 32'h1, {31'h0, e});
        xfer(1'b1, 6'h08, 4'h0, 8'h55, r, e);
        rdc(4'h2, 8'hff);
        wr(4'h4, 8'h05);
        chk("dac shadow", 32'hfff, {20'h0, dac_code_o});
        rdc(4'h4, 8'h0f);
        wr(4'h5, 8'ha3);
        chk("dac commit", 32'ha35, {20'h0, dac_code_o});
        rdc(4'h4, 8'h05);
        for (int c = 0; c < 16; c++) begin
            wr(4'h2, {~c[3:0], c[3:0]});
            chk("channel select", {24'h0, ~c[3:0], c[3:0]},
                {24'h0, neg_input_sel_o, pos_input_sel_o});
        end
        wr(4'h2, 8'h80);
        rdc(4'h2, 8'h80);
        wr(4'h2, 8'haa);
        chk("sensor pair", 32'haa, {24'h0, neg_input_sel_o,
            pos_input_sel_o});
        $display("test bus and selects done");
    endtask : t_bus
    task t_conv;
        filter_data_i <= 24'h123456;
        wr(4'hc, 8'h1f);
        wr(4'ha, 8'h28);
        wr(4'hb, 8'h04);
        gap(1'b0);
        gap(1'b0);
        chk("sinc3 n12 period", 32'd1536, n);
        k = cnv_cnt;
        repeat (768) @(posedge clk_i);
        chk("conv ticks", 32'd64, cnv_cnt - k);
        rdc(4'h7, 8'h56);
        rdc(4'h8, 8'h34);
        rdc(4'h9, 8'h12);
        rdc(4'hb, 8'h14);
        wr(4'hb, 8'h04);
        rdc(4'hb, 8'h04);
        wr(4'ha, 8'ha8);
        gap(1'b0);
        gap(1'b0);
        chk("sinc2 period", 32'd3072, n);
        wr(4'ha, 8'h08);
        gap(1'b0);
        gap(1'b0);
        chk("n30 period", 32'd3840, n);
        wr(4'hc, 8'h03);
        gap(1'b1);
        gap(1'b1);
        chk("master tick", 32'd8, n);
        wr(4'hc, 8'h1f);
        $display("test conversion rate done");
    endtask : t_conv
    task t_hold;
        wr(4'ha, 8'h28);
        gap(1'b0);
        wr(4'hb, 8'h24);
        filter_data_i <= 24'h654321;
        repeat (2000) @(posedge clk_i);
        rdc(4'h7, 8'h56);
        rdc(4'h9, 8'h12);
        rdc(4'hb, 8'h24);
        wr(4'hb, 8'h04);
        gap(1'b0);
        rdc(4'h7, 8'h21);
        rdc(4'h9, 8'h65);
        wr(4'hb, 8'h0c);
        k = rdy_cnt;
        repeat (4000) @(posedge clk_i);
        chk("results in soft reset", k, rdy_cnt);
        chk("filter clear", 32'h1, {31'h0, filter_clear_o});
        wr(4'hb, 8'h04);
        gap(1'b0);
        chk("resumed", 32'h1, {31'h0, rdy_cnt > k});
        $display("test hold and soft reset done");
    endtask : t_hold
    // ------------------------------------------------------------
    // Clock, reset, sequence and verdict
    // ------------------------------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk_i) begin
        if (result_ready_o === 1'b1) rdy_cnt <= rdy_cnt + 1;
        if (conv_clk_tick_o === 1'b1) cnv_cnt <= cnv_cnt + 1;
    end
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #720000;
        err_total++;
        end_sim();
    end
    initial begin
        {err_total, checks_done, rdy_cnt} = '0;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i, filter_data_i} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_bus();
        t_conv();
        t_hold();
        end_sim();
    end
endmodule : testbench
